// >>> core/dtc_top.sv
/*
 * Dual timer/counter with four modes and run/overflow control, reached
 * over an APB slave with zero wait states.
 * Assumes the CPU pulses a vector acknowledge for one pclk cycle when it
 * enters a timer service routine, and that all pins are asynchronous.
 */
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ps

`include "dtc_consts.svh"

module dtc_top
(
  input wire logic pclk,
  input wire logic presetn,
  input wire dtc_pkg::dtc_apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire dtc_pkg::dtc_pins_t pins,
  input wire logic vector_ack_t0,
  input wire logic vector_ack_t1,
  output logic timer_zero_irq,
  output logic timer_one_irq,
  output logic timer_one_overflow_pulse
);
  import dtc_pkg::*;

  dtc_state_t s_r;
  dtc_state_t s_nxt;
  dtc_pins_t pins_sync;
  logic [1:0] count_fall;
  logic tick;
  logic addr_hit;
  logic [31:0] read_word;
  logic wr_en;
  logic rd_setup;
  logic evt0;
  logic evt1;
  logic t0_inc;
  logic th0_inc;
  logic t1_inc;
  logic t1_stolen;
  logic t1_held;
  logic set_tf0;
  logic set_tf1;
  dtc_count_t step0;
  dtc_count_t step1;

  // ********************************************************************
  // Pin synchronisation and tick
  // ********************************************************************
  dtc_inputs #(
    .TICK_DIV(`DTC_TICK_DIV)
  ) u_inputs (
    .pclk(pclk),
    .presetn(presetn),
    .pins_raw(pins),
    .pins_sync(pins_sync),
    .count_fall(count_fall),
    .tick(tick)
  );

  // ********************************************************************
  // One count step for a timer in a given mode
  // ********************************************************************
  function automatic dtc_count_t dtc_step(
    input dtc_mode_t mode,
    input logic [7:0] lo,
    input logic [7:0] hi
  );
    dtc_count_t r;
    r.ovf = 1'b0;
    r.hi = hi;
    r.lo = lo;
    case (mode)
      DTC_MODE_13BIT:
      begin
        // Bits 7..5 of the low byte are left as they stand.
        {r.hi, r.lo[4:0]} = {hi, lo[4:0]} + 13'h0001;
        r.ovf = &{hi, lo[4:0]};
      end
      DTC_MODE_16BIT:
      begin
        {r.hi, r.lo} = {hi, lo} + 16'h0001;
        r.ovf = &{hi, lo};
      end
      DTC_MODE_AUTORELOAD:
      begin
        r.lo = (&lo) ? hi : lo + 8'h01;
        r.ovf = &lo;
      end
      DTC_MODE_SPLIT:
      begin
        r.lo = lo + 8'h01;
        r.ovf = &lo;
      end
      default:
      begin
        r.ovf = 1'b0;
      end
    endcase
    return r;
  endfunction : dtc_step

  // ********************************************************************
  // APB decode
  // ********************************************************************
  assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign rd_setup = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;

  always_comb
  begin
    addr_hit = 1'b1;
    read_word = 32'h0000_0000;
    case (apb_req.paddr)
      `DTC_OFF_CTRL:
      begin
        read_word[`DTC_CTRL_TF1_BIT] = s_r.tf1;
        read_word[`DTC_CTRL_TR1_BIT] = s_r.tr1;
        read_word[`DTC_CTRL_TF0_BIT] = s_r.tf0;
        read_word[`DTC_CTRL_TR0_BIT] = s_r.tr0;
      end
      `DTC_OFF_MODE:
      begin
        read_word[7:0] = s_r.cfg;
      end
      `DTC_OFF_T0_LO:
      begin
        read_word[7:0] = s_r.tl0;
      end
      `DTC_OFF_T0_HI:
      begin
        read_word[7:0] = s_r.th0;
      end
      `DTC_OFF_T1_LO:
      begin
        read_word[7:0] = s_r.tl1;
      end
      `DTC_OFF_T1_HI:
      begin
        read_word[7:0] = s_r.th1;
      end
      `DTC_OFF_IRQ_EN:
      begin
        read_word[1:0] = s_r.irq_en;
      end
      default:
      begin
        addr_hit = 1'b0;
      end
    endcase
  end

  // ********************************************************************
  // Count enables
  // ********************************************************************
  always_comb
  begin
    evt0 = s_r.cfg.ct0 ? count_fall[0] : tick;
    evt1 = s_r.cfg.ct1 ? count_fall[1] : tick;
    t0_inc = s_r.tr0 & evt0 &
      (~s_r.cfg.gate0 | pins_sync.ext_interrupt_pin_zero);
    t1_stolen = (s_r.cfg.mode0 == DTC_MODE_SPLIT);
    t1_held = (s_r.cfg.mode1 == DTC_MODE_SPLIT);
    th0_inc = t1_stolen & s_r.tr1 & tick;
    if (t1_held)
    begin
      t1_inc = 1'b0;
    end
    else if (t1_stolen)
    begin
      t1_inc = tick;
    end
    else
    begin
      t1_inc = s_r.tr1 & evt1 &
        (~s_r.cfg.gate1 | pins_sync.ext_interrupt_pin_one);
    end
    step0 = dtc_step(s_r.cfg.mode0, s_r.tl0, s_r.th0);
    step1 = dtc_step(s_r.cfg.mode1, s_r.tl1, s_r.th1);
  end

  // ********************************************************************
  // Next state
  // ********************************************************************
  // Software writes to a count byte win over a count in the same cycle,
  // while a flag set by hardware always wins over any clear.
  always_comb
  begin
    s_nxt = s_r;
    set_tf0 = 1'b0;
    set_tf1 = 1'b0;
    s_nxt.t1_ovf_pulse = 1'b0;
    if (t0_inc)
    begin
      s_nxt.tl0 = step0.lo;
      s_nxt.th0 = step0.hi;
      set_tf0 = step0.ovf;
    end
    if (th0_inc)
    begin
      s_nxt.th0 = s_r.th0 + 8'h01;
      set_tf1 = &s_r.th0;
    end
    if (t1_inc)
    begin
      s_nxt.tl1 = step1.lo;
      s_nxt.th1 = step1.hi;
      // Overflows still pulse out for a baud generator when not flagged.
      s_nxt.t1_ovf_pulse = step1.ovf;
      if (!t1_stolen)
      begin
        set_tf1 = step1.ovf;
      end
    end
    if (wr_en)
    begin
      case (apb_req.paddr)
        `DTC_OFF_CTRL:
        begin
          s_nxt.tf1 = apb_req.pwdata[`DTC_CTRL_TF1_BIT];
          s_nxt.tr1 = apb_req.pwdata[`DTC_CTRL_TR1_BIT];
          s_nxt.tf0 = apb_req.pwdata[`DTC_CTRL_TF0_BIT];
          s_nxt.tr0 = apb_req.pwdata[`DTC_CTRL_TR0_BIT];
        end
        `DTC_OFF_MODE:
        begin
          s_nxt.cfg = dtc_mode_cfg_t'(apb_req.pwdata[7:0]);
        end
        `DTC_OFF_T0_LO:
        begin
          s_nxt.tl0 = apb_req.pwdata[7:0];
        end
        `DTC_OFF_T0_HI:
        begin
          s_nxt.th0 = apb_req.pwdata[7:0];
        end
        `DTC_OFF_T1_LO:
        begin
          s_nxt.tl1 = apb_req.pwdata[7:0];
        end
        `DTC_OFF_T1_HI:
        begin
          s_nxt.th1 = apb_req.pwdata[7:0];
        end
        `DTC_OFF_IRQ_EN:
        begin
          s_nxt.irq_en = apb_req.pwdata[1:0];
        end
        default:
        begin
          s_nxt.irq_en = s_r.irq_en;
        end
      endcase
    end
    if (vector_ack_t0)
    begin
      s_nxt.tf0 = 1'b0;
    end
    if (vector_ack_t1)
    begin
      s_nxt.tf1 = 1'b0;
    end
    s_nxt.tf0 = s_nxt.tf0 | set_tf0;
    s_nxt.tf1 = s_nxt.tf1 | set_tf1;
    if (rd_setup)
    begin
      // Captured in the setup cycle so the access phase sees a flop.
      s_nxt.prdata = read_word;
    end
  end

  // ********************************************************************
  // State register
  // ********************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r.tl0 <= `DTC_RST_BYTE;
      s_r.th0 <= `DTC_RST_BYTE;
      s_r.tl1 <= `DTC_RST_BYTE;
      s_r.th1 <= `DTC_RST_BYTE;
      s_r.tf0 <= 1'b0;
      s_r.tr0 <= 1'b0;
      s_r.tf1 <= 1'b0;
      s_r.tr1 <= 1'b0;
      s_r.cfg <= dtc_mode_cfg_t'(`DTC_RST_BYTE);
      s_r.irq_en <= `DTC_RST_IRQ_EN;
      s_r.prdata <= 32'h0000_0000;
      s_r.t1_ovf_pulse <= 1'b0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  // The slave never stalls; an unmapped address answers with an error.
  assign pready = 1'b1;
  assign pslverr = apb_req.psel & apb_req.penable & ~addr_hit;
  assign prdata = s_r.prdata;
  assign timer_zero_irq = s_r.tf0 &
    s_r.irq_en[`DTC_IRQ_EN_T0_BIT];
  assign timer_one_irq = s_r.tf1 &
    s_r.irq_en[`DTC_IRQ_EN_T1_BIT];
  assign timer_one_overflow_pulse = s_r.t1_ovf_pulse;

endmodule : dtc_top

// >>> core/dtc_consts.svh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * dual timer/counter block.
 * Assumes it is included by its bare name after the package, once per file.
 */
`ifndef DTC_CONSTS_SVH
`define DTC_CONSTS_SVH

// ********************************************************************
// Register byte offsets on the APB slave
// ********************************************************************
`define DTC_OFF_CTRL 12'h000
`define DTC_OFF_MODE 12'h004
`define DTC_OFF_T0_LO 12'h008
`define DTC_OFF_T0_HI 12'h00c
`define DTC_OFF_T1_LO 12'h010
`define DTC_OFF_T1_HI 12'h014
`define DTC_OFF_IRQ_EN 12'h018

// ********************************************************************
// Field positions
// ********************************************************************
`define DTC_CTRL_TF1_BIT 7
`define DTC_CTRL_TR1_BIT 6
`define DTC_CTRL_TF0_BIT 5
`define DTC_CTRL_TR0_BIT 4
`define DTC_IRQ_EN_T0_BIT 0
`define DTC_IRQ_EN_T1_BIT 1

// ********************************************************************
// Reset values and timing counts
// ********************************************************************
`define DTC_RST_BYTE 8'h00
`define DTC_RST_IRQ_EN 2'h0
`define DTC_TICK_DIV 12

`endif

// >>> core/dtc_pkg.sv
/*
 * Types shared by the dual timer/counter files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package dtc_pkg;

  // ********************************************************************
  // Mode field decode
  // ********************************************************************
  typedef enum logic [1:0] {
    DTC_MODE_13BIT,
    DTC_MODE_16BIT,
    DTC_MODE_AUTORELOAD,
    DTC_MODE_SPLIT
  } dtc_mode_t;

  typedef struct packed {
    logic gate1;
    logic ct1;
    dtc_mode_t mode1;
    logic gate0;
    logic ct0;
    dtc_mode_t mode0;
  } dtc_mode_cfg_t;

  // ********************************************************************
  // Carriers
  // ********************************************************************
  typedef struct packed {
    logic count1;
    logic count0;
    logic ext_interrupt_pin_one;
    logic ext_interrupt_pin_zero;
  } dtc_pins_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } dtc_apb_req_t;

  typedef struct packed {
    logic ovf;
    logic [7:0] hi;
    logic [7:0] lo;
  } dtc_count_t;

  // ********************************************************************
  // Module state
  // ********************************************************************
  typedef struct packed {
    dtc_pins_t sync1;
    dtc_pins_t sync2;
    logic [1:0] count_prev;
    logic [3:0] div_cnt;
    logic tick;
  } dtc_in_state_t;

  typedef struct packed {
    logic [7:0] tl0;
    logic [7:0] th0;
    logic [7:0] tl1;
    logic [7:0] th1;
    logic tf0;
    logic tr0;
    logic tf1;
    logic tr1;
    dtc_mode_cfg_t cfg;
    logic [1:0] irq_en;
    logic [31:0] prdata;
    logic t1_ovf_pulse;
  } dtc_state_t;

endpackage : dtc_pkg

// >>> core/dtc_inputs.sv
/*
 * Pin synchroniser and divide-by-twelve tick for the dual timer/counter.
 * Assumes the count and gate pins are asynchronous to pclk and that pclk
 * is the oscillator clock the tick is derived from.
 */
`timescale 1ns/1ps

`include "dtc_consts.svh"

module dtc_inputs
#(
  parameter int unsigned TICK_DIV = `DTC_TICK_DIV
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire dtc_pkg::dtc_pins_t pins_raw,
  output dtc_pkg::dtc_pins_t pins_sync,
  output logic [1:0] count_fall,
  output logic tick
);
  import dtc_pkg::*;

  localparam logic [3:0] DIV_LAST = 4'(TICK_DIV - 1);

  dtc_in_state_t s_r;
  dtc_in_state_t s_nxt;

  // ********************************************************************
  // Next state
  // ********************************************************************
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.sync1 = pins_raw;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.count_prev = {s_r.sync2.count1, s_r.sync2.count0};
    s_nxt.tick = 1'b0;
    if (s_r.div_cnt == DIV_LAST)
    begin
      s_nxt.div_cnt = 4'h0;
      s_nxt.tick = 1'b1;
    end
    else
    begin
      s_nxt.div_cnt = s_r.div_cnt + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  // The edge detector looks only at the second stage and the one behind
  // it, so a metastable first stage never reaches the counters.
  assign pins_sync = s_r.sync2;
  assign count_fall = s_r.count_prev &
    ~{s_r.sync2.count1, s_r.sync2.count0};
  assign tick = s_r.tick;

endmodule : dtc_inputs

// >>> tb/dtc_pin_model.sv
/*
 * Far-side model of the count and gate pins of the dual timer/counter.
 * Assumes pclk is the block's clock and that the count pins idle high,
 * as with a pull-up, so an idle pin never reads as a falling edge.
 */
`timescale 1ns/1ps

module dtc_pin_model
(
  input wire logic pclk,
  input wire logic go,
  input wire logic sel,
  input wire logic slow,
  input wire logic [3:0] n,
  input wire logic [1:0] gate_lvl,
  output dtc_pkg::dtc_pins_t pins,
  output logic busy
);
  import dtc_pkg::*;
  logic [1:0] cnt_lvl;

  // ****************
  // Pin drive
  // ****************
  assign pins = {cnt_lvl, gate_lvl[1], gate_lvl[0]};
  // Each level is held at least two clocks, or the synchroniser may
  // swallow it.
  initial
  begin
    cnt_lvl = 2'h3;
    busy = 1'b0;
    forever
    begin
      @(posedge pclk);
      if (go)
      begin
        busy <= 1'b1;
        repeat (n)
        begin
          cnt_lvl[sel] <= 1'b0;
          repeat (slow ? 6 : 2) @(posedge pclk);
          cnt_lvl[sel] <= 1'b1;
          repeat (slow ? 6 : 2) @(posedge pclk);
        end
        busy <= 1'b0;
      end
    end
  end
endmodule : dtc_pin_model

// >>> tb/dtc_top_asserts.sv
/*
 * Port checker for dtc_top.
 * Assumes dtc_pkg is compiled first; the bind stands at the foot.
 */
`timescale 1ns/1ps

module dtc_top_asserts
(
  input wire logic pclk,
  input wire logic presetn,
  input wire dtc_pkg::dtc_apb_req_t apb_req,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire dtc_pkg::dtc_pins_t pins,
  input wire logic vector_ack_t0,
  input wire logic vector_ack_t1,
  input wire logic timer_zero_irq,
  input wire logic timer_one_irq,
  input wire logic timer_one_overflow_pulse
);
  import dtc_pkg::*;
  logic acc;
  assign acc = apb_req.psel && apb_req.penable;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ****************
  // Properties
  // ****************
  pready_high_a: assert property (pready) else $error("pready low");
  err_unmapped_a: assert property (
    acc && apb_req.paddr > 12'h018 |-> pslverr) else $error("no error");
  err_mapped_a: assert property (acc && apb_req.paddr <= 12'h018 &&
    apb_req.paddr[1:0] == 2'h0 |-> !pslverr) else $error("false error");
  reset_clear_a: assert property (
    $rose(presetn) |-> !timer_zero_irq && !timer_one_irq)
    else $error("irq after reset");
  ack0_clear_a: assert property (
    vector_ack_t0 && !acc |=> !timer_zero_irq) else $error("flag 0 kept");
  ack1_clear_a: assert property (
    vector_ack_t1 && !acc |=> !timer_one_irq) else $error("flag 1 kept");
  irq_hold_a: assert property (
    timer_zero_irq && !vector_ack_t0 && !acc |=> timer_zero_irq)
    else $error("irq 0 dropped");
  irq1_hold_a: assert property (
    timer_one_irq && !vector_ack_t1 && !acc |=> timer_one_irq)
    else $error("irq 1 dropped");
  pulse_single_a: assert property (
    timer_one_overflow_pulse |=> !timer_one_overflow_pulse [*3])
    else $error("pulse too long");
  prdata_hold_a: assert property (
    !(apb_req.psel && !apb_req.penable) |=> $stable(prdata))
    else $error("prdata moved");
  cover property ($rose(timer_zero_irq));
  cover property ($rose(timer_one_irq));
  cover property (timer_one_overflow_pulse);
  cover property (pslverr);
endmodule : dtc_top_asserts

bind dtc_top dtc_top_asserts u_chk (.pclk(pclk), .presetn(presetn),
  .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pins(pins), .vector_ack_t0(vector_ack_t0),
  .vector_ack_t1(vector_ack_t1), .timer_zero_irq(timer_zero_irq),
  .timer_one_irq(timer_one_irq),
  .timer_one_overflow_pulse(timer_one_overflow_pulse));

// >>> tb/dtc_top_tb_top.sv
/*
 * Self-checking bench for dtc_top over APB with a pin model.
 * Assumes the design, package and header are compiled first.
 */
`timescale 1ns/1ps

`include "dtc_consts.svh"

module dtc_top_tb_top;
  import dtc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  dtc_apb_req_t apb_req = '0;
  logic ack0 = 1'b0, ack1 = 1'b0, go = 1'b0, sel = 1'b0, slow = 1'b0;
  logic [3:0] n = 4'h0;
  logic [1:0] gate_lvl = 2'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, perr, irq0, irq1, pulse1, busy;
  logic [2:0] ev;
  dtc_pins_t pins;
  int errors = 0;
  int checks = 0;
  assign ev = {pulse1, irq1, irq0};
  always #20 pclk = ~pclk;

  dtc_top dut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
    .vector_ack_t0(ack0), .vector_ack_t1(ack1), .timer_zero_irq(irq0),
    .timer_one_irq(irq1), .timer_one_overflow_pulse(pulse1));
  dtc_pin_model far (.pclk(pclk), .go(go), .sel(sel), .slow(slow),
    .n(n), .gate_lvl(gate_lvl), .pins(pins), .busy(busy));

  // ****************
  // Tasks
  // ****************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_of_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  task automatic apb(input logic w, input logic [11:0] a,
    input logic [7:0] d);
    int k;
    apb_req <= '{1'b1, 1'b0, w, a, {24'h0, d}};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    rd = prdata;
    perr = pslverr;
    apb_req <= '0;
    @(posedge pclk);
    if (k >= 20)
    begin
      errors++;
      $display("ERROR %0t bus answer missing", $time);
      end_of_test();
    end
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e,
    input logic [7:0] m);
    apb(1'b0, a, 8'h00);
    chk(rd & {24'h0, m}, {24'h0, e});
  endtask : rd_chk

  task automatic wait_ev(input int w);
    int k;
    k = 0;
    while (ev[w] !== 1'b1 && k < 60)
    begin
      @(posedge pclk);
      k++;
    end
    if (k >= 60)
    begin
      errors++;
      $display("ERROR %0t event %0d missing", $time, w);
      end_of_test();
    end
  endtask : wait_ev

  task automatic ack(input int t);
    if (t == 1)
      ack1 <= 1'b1;
    else
      ack0 <= 1'b1;
    @(posedge pclk);
    ack0 <= 1'b0;
    ack1 <= 1'b0;
    @(posedge pclk);
  endtask : ack

  // Stopping right after the flag keeps the count exact: the next tick
  // is twelve clocks away.
  task automatic ovf(input int t, input logic [1:0] m, input logic [7:0] hi,
    input logic [7:0] lo, input logic [7:0] eh, input logic [7:0] el,
    input logic [7:0] msk);
    logic [11:0] b;
    logic [7:0] f;
    b = (t == 1) ? `DTC_OFF_T1_LO : `DTC_OFF_T0_LO;
    f = (t == 1) ? 8'h80 : 8'h20;
    wr(b + 12'h004, hi);
    wr(b, lo);
    wr(`DTC_OFF_MODE, (t == 1) ? {2'h0, m, 4'h0} : {6'h0, m});
    wr(`DTC_OFF_IRQ_EN, 8'h03);
    wr(`DTC_OFF_CTRL, f >> 1);
    wait_ev(t);
    wr(`DTC_OFF_CTRL, f);
    rd_chk(b, el, msk);
    rd_chk(b + 12'h004, eh, 8'hff);
    rd_chk(`DTC_OFF_CTRL, f, 8'hff);
    ack(t);
    rd_chk(`DTC_OFF_CTRL, 8'h00, 8'hff);
    $display("overflow test timer %0d mode %0d done", t, m);
  endtask : ovf

  task automatic pins_go(input logic s, input logic sl, input logic [3:0] c);
    int k;
    sel <= s;
    slow <= sl;
    n <= c;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (busy && k < 200);
    if (k >= 200)
    begin
      errors++;
      $display("ERROR %0t pin model stuck", $time);
      end_of_test();
    end
    repeat (4) @(posedge pclk);
  endtask : pins_go

  // ****************
  // Sequence
  // ****************
  initial
  begin
    repeat (20000) @(posedge pclk);
    errors++;
    $display("ERROR %0t run timed out", $time);
    end_of_test();
  end

  initial
  begin
    logic [7:0] v;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int a = 0; a <= 24; a += 4)
      rd_chk(a[11:0], 8'h00, 8'hff);
    apb(1'b1, 12'h01c, 8'hff);
    chk(perr, 1'b1);
    apb(1'b0, 12'h01c, 8'h00);
    chk(rd, 32'h0000_0000);
    chk(perr, 1'b1);
    $display("reset and map test done");
    for (int t = 0; t < 2; t++)
    begin
      ovf(t, 2'h0, 8'hff, 8'h1f, 8'h00, 8'h00, 8'h1f);
      ovf(t, 2'h1, 8'hff, 8'hff, 8'h00, 8'h00, 8'hff);
      ovf(t, 2'h2, 8'ha5, 8'hff, 8'ha5, 8'ha5, 8'hff);
    end
    wr(`DTC_OFF_T0_LO, 8'h00);
    wr(`DTC_OFF_T1_LO, 8'h00);
    wr(`DTC_OFF_MODE, 8'h99);
    wr(`DTC_OFF_CTRL, 8'h50);
    repeat (40) @(posedge pclk);
    rd_chk(`DTC_OFF_T0_LO, 8'h00, 8'hff);
    gate_lvl <= 2'h1;
    repeat (40) @(posedge pclk);
    wr(`DTC_OFF_CTRL, 8'h40);
    apb(1'b0, `DTC_OFF_T0_LO, 8'h00);
    v = rd[7:0];
    chk(v != 8'h00, 1'b1);
    repeat (30) @(posedge pclk);
    rd_chk(`DTC_OFF_T0_LO, v, 8'hff);
    rd_chk(`DTC_OFF_T1_LO, 8'h00, 8'hff);
    gate_lvl <= 2'h2;
    repeat (40) @(posedge pclk);
    wr(`DTC_OFF_CTRL, 8'h00);
    apb(1'b0, `DTC_OFF_T1_LO, 8'h00);
    chk(rd[7:0] != 8'h00, 1'b1);
    $display("gate test done");
    gate_lvl <= 2'h0;
    wr(`DTC_OFF_MODE, 8'h55);
    wr(`DTC_OFF_T0_LO, 8'h00);
    wr(`DTC_OFF_T1_LO, 8'h00);
    wr(`DTC_OFF_CTRL, 8'h50);
    pins_go(1'b0, 1'b0, 4'h5);
    pins_go(1'b1, 1'b1, 4'h3);
    wr(`DTC_OFF_CTRL, 8'h00);
    rd_chk(`DTC_OFF_T0_LO, 8'h05, 8'hff);
    rd_chk(`DTC_OFF_T1_LO, 8'h03, 8'hff);
    $display("pin count test done");
    wr(`DTC_OFF_MODE, 8'h33);
    wr(`DTC_OFF_T1_LO, 8'h12);
    wr(`DTC_OFF_T0_LO, 8'h00);
    wr(`DTC_OFF_T0_HI, 8'hff);
    wr(`DTC_OFF_CTRL, 8'h40);
    wait_ev(1);
    wr(`DTC_OFF_CTRL, 8'h80);
    rd_chk(`DTC_OFF_T0_HI, 8'h00, 8'hff);
    rd_chk(`DTC_OFF_T0_LO, 8'h00, 8'hff);
    rd_chk(`DTC_OFF_T1_LO, 8'h12, 8'hff);
    rd_chk(`DTC_OFF_CTRL, 8'h80, 8'hff);
    ack(1);
    wr(`DTC_OFF_T1_LO, 8'hff);
    wr(`DTC_OFF_T1_HI, 8'hff);
    wr(`DTC_OFF_MODE, 8'h13);
    wait_ev(2);
    chk(irq1, 1'b0);
    wr(`DTC_OFF_MODE, 8'h33);
    rd_chk(`DTC_OFF_T1_LO, 8'h00, 8'hff);
    rd_chk(`DTC_OFF_T1_HI, 8'h00, 8'hff);
    rd_chk(`DTC_OFF_CTRL, 8'h00, 8'hff);
    $display("split mode test done");
    wr(`DTC_OFF_CTRL, 8'hf0);
    chk({irq1, irq0}, 2'h3);
    wr(`DTC_OFF_IRQ_EN, 8'h00);
    chk({irq1, irq0}, 2'h0);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({pulse1, irq1, irq0}, 3'h0);
    rd_chk(`DTC_OFF_CTRL, 8'h00, 8'hff);
    rd_chk(`DTC_OFF_MODE, 8'h00, 8'hff);
    $display("second reset test done");
    end_of_test();
  end
endmodule : dtc_top_tb_top
